// ### logic/epi_pkg.sv
// Constants and types shared by the external pin interrupt block
package epi_pkg;
  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] OFF_SENSE = 8'h00;
  localparam logic [7:0] OFF_STATUS_SENSE = 8'h04;
  localparam logic [7:0] OFF_ENABLE = 8'h08;
  localparam logic [7:0] OFF_FLAGS = 8'h0C;
  localparam logic [7:0] OFF_PIN_STATE = 8'h10;
  localparam int BIT_ZERO_SENSE = 0;
  localparam int BIT_ONE_SENSE = 2;
  localparam int BIT_EDGE_SELECT = 6;
  localparam int BIT_LINE_ONE = 7;
  localparam int BIT_LINE_ZERO = 6;
  localparam int BIT_LINE_TWO = 5;
  localparam int BIT_WAKE_STATE = 4;
  localparam logic [3:0] RST_SENSE = 4'h0;
  localparam logic RST_EDGE_SELECT = 1'h0;
  localparam logic [2:0] RST_ENABLE = 3'h0;
  localparam logic [2:0] RST_FLAGS = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CLK_PERIOD_NS = 20;
  localparam int WDT_PERIOD_NS = 1000;
  localparam int WDT_TICK_CYCLES = (WDT_PERIOD_NS / CLK_PERIOD_NS < 1) ? 1 :
                                   WDT_PERIOD_NS / CLK_PERIOD_NS;
  localparam int STARTUP_CYCLES_DEF = 64;
  localparam int CNT_W = 16;

  typedef enum logic [1:0] {
    SENSE_LOW = 2'h0,
    SENSE_ANY = 2'h1,
    SENSE_FALL = 2'h2,
    SENSE_RISE = 2'h3
  } epi_sense_t;

  typedef enum logic [1:0] {
    WK_IDLE = 2'h0,
    WK_SAMPLE = 2'h1,
    WK_STARTUP = 2'h3
  } epi_wake_t;
endpackage

// ### logic/epi_pin_detect.sv
// Two-stage pin synchroniser with edge detector
`timescale 1ns/10ps
module epi_pin_detect
  import epi_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic pin_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
  } epi_pin_state_t;

  epi_pin_state_t r;
  epi_pin_state_t next_r;

  always_comb begin
    next_r = r;
    next_r.s1 = pin_i;
    next_r.s2 = r.s1;
    if (run_i) begin
      next_r.prev = r.s2;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '{s1: 1'h1, s2: 1'h1, prev: 1'h1};
    end else begin
      r <= next_r;
    end
  end

  // Compare current sample with the previous one
  assign level_o = r.s2;
  assign rise_o = run_i & r.s2 & ~r.prev;
  assign fall_o = run_i & ~r.s2 & r.prev;
endmodule

// ### logic/epi_tick_div.sv
// Divider making a one-cycle watchdog sampling pulse
`timescale 1ns/10ps
module epi_tick_div
  import epi_pkg::*;
#(
  parameter int DIV = WDT_TICK_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  output logic tick_o
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic tick;
  } epi_div_state_t;

  epi_div_state_t r;
  epi_div_state_t next_r;

  always_comb begin
    next_r = r;
    next_r.tick = 1'h0;
    if (r.cnt == CNT_W'(DIV - 1)) begin
      next_r.cnt = '0;
      next_r.tick = 1'h1;
    end else begin
      next_r.cnt = r.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign tick_o = r.tick;
endmodule

// ### logic/epi_top.sv
// External pin interrupt controller with AXI4-Lite register access
//
// Behaviour
// - Pins request regardless of port direction
// - Line two edge only; lines zero/one level too
// - Level mode requests while pin held low
// - Sync edges on I/O clock; level, line two always
// - Level wake needs two watchdog samples low
// - Level gone after start-up: wake, no interrupt
// - Line one sense: low, any, fall, rise
// - Line zero sense: same encoding
// - Sample pin first; longer pulses always caught
// - Line two edge bit: zero fall, one rise
// - Enable bits 7,6,5 gated by global bit at irq_req_o; irq_o ungated
// - Each line requests its own vector
// - Edge sets flag at bits 7,6,5
// - Flag cleared by vector or writing one
// - Flag held clear in level mode
// - Disabled line two buffer off may set flag
`timescale 1ns/10ps
module epi_top
  import epi_pkg::*;
#(
  parameter int STARTUP_CYCLES = STARTUP_CYCLES_DEF
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ext_irq_line_zero_i,
  input wire logic ext_irq_line_one_i,
  input wire logic ext_irq_line_two_i,
  input wire logic cpu_status_word_global_i,
  input wire logic [2:0] vec_ack_i,
  input wire logic io_clk_halt_i,
  input wire logic power_down_i,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [2:0] irq_req_o,
  output logic irq_o,
  output logic wake_o
);
  typedef struct packed {
    logic [3:0] sense;
    logic edge_sel;
    logic [2:0] en;
    logic [2:0] flags;
    logic awrdy;
    logic awhave;
    logic [AXI_ADDR_W-1:0] awaddr;
    logic wrdy;
    logic whave;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arrdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    epi_wake_t wst;
    logic [CNT_W-1:0] cnt;
    logic [2:0] irq_req;
    logic irq;
    logic wake;
  } epi_state_t;

  epi_state_t r;
  epi_state_t next_r;

  logic [2:0] level;
  logic [2:0] rise;
  logic [2:0] fall;
  logic [2:0] set;
  logic [2:0] clr;
  logic [2:0] pend;
  logic [1:0] lvl_mode;
  logic [1:0] low;
  logic wsrc;
  logic lvl_block;
  logic do_wr;
  logic wr_ok;
  logic wdt_tick;
  logic buf_off;
  logic line_two_seen;
  epi_sense_t mode [2];

  // Sleep turns off the disabled line two input buffer
  assign buf_off = io_clk_halt_i & ~r.en[2];
  assign line_two_seen = ext_irq_line_two_i & ~buf_off;

  // Pins are read straight, whatever the port direction
  epi_pin_detect u_line_zero (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .run_i(~io_clk_halt_i),
    .pin_i(ext_irq_line_zero_i),
    .level_o(level[0]),
    .rise_o(rise[0]),
    .fall_o(fall[0])
  );

  epi_pin_detect u_line_one (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .run_i(~io_clk_halt_i),
    .pin_i(ext_irq_line_one_i),
    .level_o(level[1]),
    .rise_o(rise[1]),
    .fall_o(fall[1])
  );

  // Line two keeps detecting in every sleep mode
  epi_pin_detect u_line_two (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .run_i(1'h1),
    .pin_i(line_two_seen),
    .level_o(level[2]),
    .rise_o(rise[2]),
    .fall_o(fall[2])
  );

  epi_tick_div #(
    .DIV(WDT_TICK_CYCLES)
  ) u_wdt_div (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .tick_o(wdt_tick)
  );

  always_comb begin
    next_r = r;
    next_r.wake = 1'h0;
    mode[0] = epi_sense_t'(r.sense[BIT_ZERO_SENSE +: 2]);
    mode[1] = epi_sense_t'(r.sense[BIT_ONE_SENSE +: 2]);
    low = ~level[1:0];
    // Edge or change selection per line
    for (int i = 0; i < 2; i++) begin
      lvl_mode[i] = (mode[i] == SENSE_LOW);
      unique case (mode[i])
        SENSE_LOW: set[i] = 1'h0;
        SENSE_ANY: set[i] = rise[i] | fall[i];
        SENSE_FALL: set[i] = fall[i];
        SENSE_RISE: set[i] = rise[i];
      endcase
    end
    set[2] = r.edge_sel ? rise[2] : fall[2];
    // Write channel
    if (s_axi_awvalid_i && r.awrdy) begin
      next_r.awhave = 1'h1;
      next_r.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && r.wrdy) begin
      next_r.whave = 1'h1;
      next_r.wdata = s_axi_wdata_i;
      next_r.wstrb = s_axi_wstrb_i;
    end
    if (r.bvalid && s_axi_bready_i) begin
      next_r.bvalid = 1'h0;
    end
    do_wr = next_r.awhave && next_r.whave && !next_r.bvalid;
    wr_ok = (next_r.awaddr == OFF_SENSE) || (next_r.awaddr == OFF_STATUS_SENSE) ||
            (next_r.awaddr == OFF_ENABLE) || (next_r.awaddr == OFF_FLAGS) ||
            (next_r.awaddr == OFF_PIN_STATE);
    clr = vec_ack_i;
    if (do_wr) begin
      next_r.awhave = 1'h0;
      next_r.whave = 1'h0;
      next_r.bvalid = 1'h1;
      next_r.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
      if (next_r.wstrb[0]) begin
        unique case (next_r.awaddr)
          OFF_SENSE: next_r.sense = next_r.wdata[3:0];
          OFF_STATUS_SENSE: next_r.edge_sel = next_r.wdata[BIT_EDGE_SELECT];
          OFF_ENABLE: next_r.en = {next_r.wdata[BIT_LINE_TWO],
                                   next_r.wdata[BIT_LINE_ONE],
                                   next_r.wdata[BIT_LINE_ZERO]};
          OFF_FLAGS: clr = clr | {next_r.wdata[BIT_LINE_TWO],
                                  next_r.wdata[BIT_LINE_ONE],
                                  next_r.wdata[BIT_LINE_ZERO]};
          default: next_r.bresp = next_r.bresp;
        endcase
      end
    end
    // Flags: a new event wins over a clear
    for (int i = 0; i < 3; i++) begin
      next_r.flags[i] = set[i] | (r.flags[i] & ~clr[i]);
    end
    next_r.flags[1:0] = next_r.flags[1:0] & ~lvl_mode;
    // Read channel
    if (s_axi_arvalid_i && r.arrdy) begin
      next_r.rvalid = 1'h1;
      next_r.rresp = RESP_OKAY;
      next_r.rdata = '0;
      unique case (s_axi_araddr_i)
        OFF_SENSE: next_r.rdata[3:0] = r.sense;
        OFF_STATUS_SENSE: next_r.rdata[BIT_EDGE_SELECT] = r.edge_sel;
        OFF_ENABLE: begin
          next_r.rdata[BIT_LINE_ONE] = r.en[1];
          next_r.rdata[BIT_LINE_ZERO] = r.en[0];
          next_r.rdata[BIT_LINE_TWO] = r.en[2];
        end
        OFF_FLAGS: begin
          next_r.rdata[BIT_LINE_ONE] = r.flags[1];
          next_r.rdata[BIT_LINE_ZERO] = r.flags[0];
          next_r.rdata[BIT_LINE_TWO] = r.flags[2];
        end
        OFF_PIN_STATE: begin
          next_r.rdata[2:0] = level;
          next_r.rdata[BIT_WAKE_STATE +: 2] = r.wst;
        end
        default: next_r.rresp = RESP_SLVERR;
      endcase
    end else if (r.rvalid && s_axi_rready_i) begin
      next_r.rvalid = 1'h0;
    end
    next_r.awrdy = !next_r.awhave && !next_r.bvalid;
    next_r.wrdy = !next_r.whave && !next_r.bvalid;
    next_r.arrdy = !next_r.rvalid;
    // Power-down wake filter
    wsrc = |(lvl_mode & low & r.en[1:0]);
    unique case (r.wst)
      WK_IDLE: begin
        if (power_down_i && wdt_tick && wsrc) begin
          next_r.wst = WK_SAMPLE;
        end else if (power_down_i && r.flags[2] && r.en[2]) begin
          next_r.wst = WK_STARTUP;
          next_r.cnt = CNT_W'(STARTUP_CYCLES - 1);
        end
      end
      WK_SAMPLE: begin
        if (wdt_tick) begin
          if (wsrc) begin
            next_r.wst = WK_STARTUP;
            next_r.cnt = CNT_W'(STARTUP_CYCLES - 1);
          end else begin
            next_r.wst = WK_IDLE;
          end
        end
      end
      WK_STARTUP: begin
        if (r.cnt == '0) begin
          next_r.wst = WK_IDLE;
          next_r.wake = 1'h1;
        end else begin
          next_r.cnt = r.cnt - CNT_W'(1);
        end
      end
      default: next_r.wst = WK_IDLE;
    endcase
    // Level request only once awake, and only if still low
    lvl_block = power_down_i || (r.wst != WK_IDLE);
    for (int i = 0; i < 2; i++) begin
      pend[i] = lvl_mode[i] ? (low[i] & ~lvl_block) : r.flags[i];
    end
    pend[2] = r.flags[2];
    next_r.irq_req = pend & r.en & {3{cpu_status_word_global_i}};
    next_r.irq = |(pend & r.en);
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
      r.sense <= RST_SENSE;
      r.edge_sel <= RST_EDGE_SELECT;
      r.en <= RST_ENABLE;
      r.flags <= RST_FLAGS;
      r.wst <= WK_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign s_axi_awready_o = r.awrdy;
  assign s_axi_wready_o = r.wrdy;
  assign s_axi_bresp_o = r.bresp;
  assign s_axi_bvalid_o = r.bvalid;
  assign s_axi_arready_o = r.arrdy;
  assign s_axi_rdata_o = r.rdata;
  assign s_axi_rresp_o = r.rresp;
  assign s_axi_rvalid_o = r.rvalid;
  assign irq_req_o = r.irq_req;
  assign irq_o = r.irq;
  assign wake_o = r.wake;

  property p_lvl_flag_clear;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (mode[0] == SENSE_LOW) |=> !r.flags[0];
  endproperty
  a_lvl_flag_clear: assert property (p_lvl_flag_clear) else $error("flag set in level mode");

  property p_rise_sets;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (mode[1] == SENSE_RISE && rise[1]) |=> r.flags[1] ##1 irq_o || !r.en[1];
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("rising edge lost");

  property p_any_sets;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (mode[0] == SENSE_ANY && (rise[0] || fall[0])) |=> r.flags[0];
  endproperty
  a_any_sets: assert property (p_any_sets) else $error("change lost");

  property p_two_fall;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (!r.edge_sel && fall[2]) |=> r.flags[2];
  endproperty
  a_two_fall: assert property (p_two_fall) else $error("line two fall lost");

  property p_w1c;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (clr[2] && !set[2]) |=> !r.flags[2];
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared");

  property p_vector_req;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (r.flags[2] && r.en[2] && cpu_status_word_global_i) |=> irq_req_o[2];
  endproperty
  a_vector_req: assert property (p_vector_req) else $error("vector request missing");

  property p_global_gate;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !cpu_status_word_global_i |=> (irq_req_o == 3'h0);
  endproperty
  a_global_gate: assert property (p_global_gate) else $error("request without global");

  property p_level_req;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (lvl_mode[0] && low[0] && r.en[0] && cpu_status_word_global_i && !lvl_block)
      |=> irq_req_o[0];
  endproperty
  a_level_req: assert property (p_level_req) else $error("level request missing");

  property p_two_samples;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (r.wst == WK_SAMPLE && wdt_tick && wsrc) |=> (r.wst == WK_STARTUP);
  endproperty
  a_two_samples: assert property (p_two_samples) else $error("second sample ignored");

  property p_wake_end;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (r.wst == WK_STARTUP && r.cnt == '0) |=> wake_o && (r.wst == WK_IDLE);
  endproperty
  a_wake_end: assert property (p_wake_end) else $error("no wake after start-up");
endmodule

// ### testbench/epi_pin_source.sv
// Behavioural source driving the three external interrupt pins
`timescale 1ns/10ps
module epi_pin_source (
  input wire logic core_clk_i,
  output logic [2:0] pins_o
);
  initial pins_o = 3'h7;
  // Level lands after an edge, holds until next command
  task automatic drive(input int idx, input logic val);
    @(posedge core_clk_i);
    pins_o[idx] <= val;
  endtask
endmodule

// ### testbench/epi_top_bench.sv
// Self-checking bench for the external pin interrupt block
`timescale 1ns/10ps
module epi_top_bench;
  import epi_pkg::*;
  logic core_clk_i, rst_n_i, glob, halt, pdown, irq, wake;
  logic [2:0] ack, irq_req, pins;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  int mismatches, compares, n;

  epi_top #(.STARTUP_CYCLES(4)) DUT (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .ext_irq_line_zero_i(pins[0]), .ext_irq_line_one_i(pins[1]),
    .ext_irq_line_two_i(pins[2]), .cpu_status_word_global_i(glob),
    .vec_ack_i(ack), .io_clk_halt_i(halt), .power_down_i(pdown),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .irq_req_o(irq_req), .irq_o(irq), .wake_o(wake)
  );
  epi_pin_source u_src (.core_clk_i(core_clk_i), .pins_o(pins));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int t;
    t = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(posedge core_clk_i);
      t++;
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!(bvalid && bready) && t < 50);
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
    int t;
    t = 0;
    araddr <= a;
    arvalid <= 1'h1;
    do begin
      @(posedge core_clk_i);
      t++;
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!(rvalid && rready) && t < 50);
    chk("rdata", {24'h0, ed}, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask

  task automatic tally_and_finish();
    $display("Totals: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    core_clk_i = 1'h0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  initial begin
    #400000;
    mismatches++;
    tally_and_finish();
  end

  initial begin
    mismatches = 0;
    compares = 0;
    rst_n_i = 1'h0;
    glob = 1'h1;
    halt = 1'h0;
    pdown = 1'h0;
    ack = 3'h0;
    {awvalid, wvalid, arvalid} = 3'h0;
    {bready, rready} = 2'h3;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    cyc(10);
    rst_n_i <= 1'h1;
    cyc(1);
    rdc(OFF_SENSE, 8'h00, RESP_OKAY);
    rdc(OFF_STATUS_SENSE, 8'h00, RESP_OKAY);
    rdc(OFF_ENABLE, 8'h00, RESP_OKAY);
    rdc(OFF_FLAGS, 8'h00, RESP_OKAY);
    rdc(8'h14, 8'h00, RESP_SLVERR);
    wr(8'h14, 8'hFF, RESP_SLVERR);
    // Line zero edge modes, line one on falling edge
    wr(OFF_ENABLE, 8'h40, RESP_OKAY);
    for (int m = 1; m < 4; m++) begin
      wr(OFF_SENSE, 8'h08 | 8'(m), RESP_OKAY);
      u_src.drive(0, 1'h0);
      cyc(6);
      chk("irq_req0", (m != 3), irq_req[0]);
      rdc(OFF_FLAGS, (m != 3) ? 8'h40 : 8'h00, RESP_OKAY);
      wr(OFF_FLAGS, 8'h40, RESP_OKAY);
      u_src.drive(0, 1'h1);
      cyc(6);
      rdc(OFF_FLAGS, (m != 2) ? 8'h40 : 8'h00, RESP_OKAY);
      wr(OFF_FLAGS, 8'h40, RESP_OKAY);
      rdc(OFF_FLAGS, 8'h00, RESP_OKAY);
    end
    // Two-cycle pulse on line one, cleared by vector
    wr(OFF_ENABLE, 8'h80, RESP_OKAY);
    u_src.drive(1, 1'h0);
    cyc(1);
    u_src.drive(1, 1'h1);
    cyc(5);
    chk("irq_req", 3'h2, irq_req);
    ack <= 3'h2;
    cyc(1);
    ack <= 3'h0;
    cyc(4);
    chk("irq_req", 3'h0, irq_req);
    rdc(OFF_FLAGS, 8'h00, RESP_OKAY);
    // Line one on rising edge only
    wr(OFF_SENSE, 8'h0C, RESP_OKAY);
    u_src.drive(1, 1'h0);
    cyc(3);
    u_src.drive(1, 1'h1);
    cyc(6);
    chk("irq_req", 3'h2, irq_req);
    wr(OFF_FLAGS, 8'h80, RESP_OKAY);
    rdc(OFF_FLAGS, 8'h00, RESP_OKAY);
    // Line zero low level, global gating
    wr(OFF_SENSE, 8'h08, RESP_OKAY);
    wr(OFF_ENABLE, 8'h40, RESP_OKAY);
    u_src.drive(0, 1'h0);
    cyc(6);
    chk("irq_req", 3'h1, irq_req);
    rdc(OFF_FLAGS, 8'h00, RESP_OKAY);
    glob <= 1'h0;
    cyc(4);
    chk("irq_req", 3'h0, irq_req);
    chk("irq", 1'h1, irq);
    glob <= 1'h1;
    u_src.drive(0, 1'h1);
    cyc(6);
    chk("irq_req", 3'h0, irq_req);
    // Level wake from power-down
    pdown <= 1'h1;
    u_src.drive(0, 1'h0);
    n = 0;
    while (wake !== 1'h1 && n < 400) begin
      @(posedge core_clk_i);
      n++;
    end
    chk("wake", 1'h1, wake);
    chk("wake after two ticks", 1'h1, n > 50);
    pdown <= 1'h0;
    cyc(6);
    chk("irq_req", 3'h1, irq_req);
    u_src.drive(0, 1'h1);
    // Line two edges and safe edge change
    wr(OFF_ENABLE, 8'h20, RESP_OKAY);
    u_src.drive(2, 1'h0);
    cyc(6);
    chk("irq_req", 3'h4, irq_req);
    rdc(OFF_FLAGS, 8'h20, RESP_OKAY);
    wr(OFF_FLAGS, 8'h20, RESP_OKAY);
    cyc(6);
    rdc(OFF_FLAGS, 8'h00, RESP_OKAY);
    wr(OFF_ENABLE, 8'h00, RESP_OKAY);
    wr(OFF_STATUS_SENSE, 8'h40, RESP_OKAY);
    wr(OFF_FLAGS, 8'h20, RESP_OKAY);
    wr(OFF_ENABLE, 8'h20, RESP_OKAY);
    u_src.drive(2, 1'h1);
    cyc(6);
    rdc(OFF_FLAGS, 8'h20, RESP_OKAY);
    wr(OFF_FLAGS, 8'h20, RESP_OKAY);
    wr(OFF_ENABLE, 8'h00, RESP_OKAY);
    wr(OFF_STATUS_SENSE, 8'h00, RESP_OKAY);
    halt <= 1'h1;
    cyc(6);
    halt <= 1'h0;
    cyc(6);
    rdc(OFF_FLAGS, 8'h20, RESP_OKAY);
    tally_and_finish();
  end
endmodule
